// File: src/sss_pkg.sv
`default_nettype none
package sss_pkg;
    // Register word indices on the Avalon word address
    localparam logic [2:0] IDX_BUF = 3'h0;
    localparam logic [2:0] IDX_CON1 = 3'h1;
    localparam logic [2:0] IDX_CON3 = 3'h2;
    localparam logic [2:0] IDX_STAT = 3'h3;
    localparam logic [2:0] IDX_IRQ = 3'h4;
    localparam logic [2:0] IDX_MASK = 3'h5;
    // Control one fields
    localparam int C1_WRITE_COLLISION_FLAG = 7;
    localparam int C1_OVF = 6;
    localparam int C1_EN = 5;
    localparam int C1_CKP = 4;
    localparam logic [3:0] MODE_MST_MAX = 4'h3;
    localparam logic [3:0] MODE_SS_SLAVE = 4'h4;
    localparam logic [3:0] MODE_SLAVE = 4'h5;
    // Status and control three fields
    localparam int ST_SMP = 7;
    localparam int ST_CKE = 6;
    localparam int ST_BF = 0;
    localparam int C3_BUFFER_OVERWRITE_ENABLE = 4;
    // Interrupt status and mask layout
    localparam int IRQ_BYTE = 0;
    localparam int IRQ_WRITE_COLLISION_FLAG = 1;
    // Bit and edge counts
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [3:0] HALF_LAST = 4'hf;
    // Master half-period in core clocks per rate code
    localparam logic [7:0] HALF_DIV0 = 8'h02;
    localparam logic [7:0] HALF_DIV1 = 8'h08;
    localparam logic [7:0] HALF_DIV2 = 8'h20;

    typedef enum logic {MST_IDLE, MST_RUN} sss_mst_e;

    typedef struct packed {
        logic read;
        logic write;
        logic [2:0] address;
        logic [31:0] writedata;
    } sss_avs_req_s;

    typedef struct packed {
        logic [1:0] sckS;
        logic [1:0] ssS;
        logic [1:0] sdiS;
        logic sckD;
        logic ssD;
        logic [7:0] buffer;
        logic [7:0] shifter;
        logic [7:0] con1;
        logic [7:0] con3;
        logic [7:0] stat;
        logic [7:0] irqSt;
        logic [7:0] irqMask;
        logic [2:0] bitCnt;
        logic outBit;
        logic rdValid;
        logic [31:0] rdData;
        logic [7:0] divCnt;
        logic [3:0] halfCnt;
        logic mSck;
        sss_mst_e mst;
    } sss_state_s;

    function automatic logic [7:0] sss_half(input logic [1:0] rate);
        unique case (rate)
            2'h0: sss_half = HALF_DIV0;
            2'h1: sss_half = HALF_DIV1;
            2'h2: sss_half = HALF_DIV2;
            2'h3: sss_half = HALF_DIV2;
        endcase
    endfunction : sss_half
endpackage : sss_pkg
`default_nettype wire

// File: src/sss_port.sv
// Our own choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Mode code 0100 selects select-controlled slave
// - Select low enables shifting, drives data out
// - Select high floats data out at once
// - Select high holds serial logic in reset
// - Select high or enable clear zeroes counter
// - Select fall starts frame, rise realigns
// - Slave shifts on serial clock during sleep
// - Eighth bit sets interrupt flag, wakes device if unmasked
// - Master sleep freezes transfer in place
// - Master resumes frozen transfer after wake
// - MSB first; full byte fills buffer if empty or overwrite on, flags
// - Buffer write while shifting sets collision
module sss_port
    import sss_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire sss_avs_req_s avsReq,
    output logic [31:0] avsReadData,
    output logic avsWaitRequest,
    input wire logic sckIn,
    output logic sckOut,
    output logic sckOeN,
    input wire logic ssN,
    input wire logic sdiIn,
    output logic sdoOut,
    output logic sdoOeN,
    input wire logic sleep,
    output logic irq,
    output logic wakeReq
);

    sss_state_s r;
    sss_state_s n;

    logic sck;
    logic ss;
    logic serial_data_in;
    logic en;
    logic slave;
    logic master;
    logic ssCtl;
    logic clock_idle_polarity;
    logic cke;
    logic portReset;
    logic sEdge;
    logic lead;
    logic trail;
    logic mLead;
    logic mTrail;
    logic sampleE;
    logic shiftE;
    logic busy;
    logic byteDone;
    logic keepOld;
    logic wrBuf;
    logic rdAcc;
    logic [7:0] half;
    logic [7:0] newByte;

    ////////////////////////////////////////////////////////////////////////
    // Decode of mode and synchronised pins
    assign sck = r.sckS[1];
    assign ss = r.ssS[1];
    assign serial_data_in = r.sdiS[1];
    assign en = r.con1[C1_EN];
    assign clock_idle_polarity = r.con1[C1_CKP];
    assign cke = r.stat[ST_CKE];
    assign ssCtl = r.con1[3:0] == MODE_SS_SLAVE;
    assign slave = en & (ssCtl | r.con1[3:0] == MODE_SLAVE);
    assign master = en & (r.con1[3:0] <= MODE_MST_MAX);
    // Select high or enable low holds the port in reset
    assign portReset = ~en | (ssCtl & ss);
    assign half = sss_half(r.con1[1:0]);
    assign newByte = {r.shifter[6:0], serial_data_in};

    ////////////////////////////////////////////////////////////////////////
    // Edge sources: external clock as slave, own divider as master
    assign sEdge = slave & ~portReset & (sck ^ r.sckD);
    assign mLead = master & (r.mst == MST_RUN) & ~sleep
        & (r.divCnt == half - 8'h01) & (r.mSck == clock_idle_polarity);
    assign mTrail = master & (r.mst == MST_RUN) & ~sleep
        & (r.divCnt == half - 8'h01) & (r.mSck != clock_idle_polarity);
    assign lead = (sEdge & (sck != clock_idle_polarity)) | mLead;
    assign trail = (sEdge & (sck == clock_idle_polarity)) | mTrail;
    // Sample phase bit ignored: slave always samples mid-cell
    assign sampleE = cke ? lead : trail;
    assign shiftE = cke ? trail : lead;
    assign byteDone = sampleE & (r.bitCnt == BIT_LAST);
    assign keepOld = r.stat[ST_BF] & ~r.con3[C3_BUFFER_OVERWRITE_ENABLE];
    // Same-cycle sample counts as busy so a load never races a shift
    assign busy = (r.bitCnt != 3'h0) | (r.mst == MST_RUN) | sampleE;
    assign rdAcc = avsReq.read & r.rdValid;
    assign wrBuf = avsReq.write & (avsReq.address == IDX_BUF);

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic; bus clears first, hardware sets win after
    always_comb begin
        n = r;
        n.sckS = {r.sckS[0], sckIn};
        n.ssS = {r.ssS[0], ssN};
        n.sdiS = {r.sdiS[0], sdiIn};
        n.sckD = sck;
        n.ssD = ss;
        n.rdValid = avsReq.read & ~r.rdValid;
        // Read data registered, one wait state per read
        if (avsReq.read & ~r.rdValid) begin
            n.rdData = 32'h0;
            unique case (avsReq.address)
                IDX_BUF: n.rdData[7:0] = r.buffer;
                IDX_CON1: n.rdData[7:0] = r.con1;
                IDX_CON3: n.rdData[7:0] = r.con3;
                IDX_STAT: n.rdData[7:0] = r.stat;
                IDX_IRQ: n.rdData[7:0] = r.irqSt;
                IDX_MASK: n.rdData[7:0] = r.irqMask;
                default: n.rdData = 32'h0;
            endcase
        end
        // Reading the buffer empties it
        if (rdAcc & (avsReq.address == IDX_BUF)) begin
            n.stat[ST_BF] = 1'b0;
        end
        if (avsReq.write) begin
            unique case (avsReq.address)
                IDX_BUF: begin
                    if (!busy) begin
                        n.buffer = avsReq.writedata[7:0];
                        n.shifter = avsReq.writedata[7:0];
                        n.outBit = avsReq.writedata[7];
                        if (master) begin
                            n.mst = MST_RUN;
                            n.divCnt = 8'h00;
                            n.halfCnt = 4'h0;
                        end
                    end
                end
                IDX_CON1: n.con1 = avsReq.writedata[7:0];
                IDX_CON3: n.con3 = avsReq.writedata[7:0];
                IDX_STAT: n.stat[7:6] = avsReq.writedata[7:6];
                IDX_IRQ: n.irqSt = r.irqSt & ~avsReq.writedata[7:0];
                IDX_MASK: n.irqMask = avsReq.writedata[7:0];
                default: n.rdData = r.rdData;
            endcase
        end
        // Discarded load flags a collision
        if (wrBuf & busy) begin
            n.con1[C1_WRITE_COLLISION_FLAG] = 1'b1;
            n.irqSt[IRQ_WRITE_COLLISION_FLAG] = 1'b1;
        end
        // Master divider stalls while asleep, no state lost
        if (master & (r.mst == MST_RUN) & ~sleep) begin
            n.divCnt = 8'(r.divCnt + 8'h01);
            if (r.divCnt == half - 8'h01) begin
                n.divCnt = 8'h00;
                n.mSck = ~r.mSck;
                n.halfCnt = 4'(r.halfCnt + 4'h1);
                if (r.halfCnt == HALF_LAST) begin
                    n.mst = MST_IDLE;
                end
            end
        end
        if (r.mst == MST_IDLE) begin
            n.mSck = clock_idle_polarity;
        end
        // MSB-first shifting on the programmed edges
        if (sampleE) begin
            n.shifter = newByte;
            n.bitCnt = 3'(r.bitCnt + 3'h1);
        end
        if (shiftE) begin
            n.outBit = r.shifter[7];
        end
        if (byteDone) begin
            n.irqSt[IRQ_BYTE] = 1'b1;
            if (keepOld) begin
                n.con1[C1_OVF] = 1'b1;
            end else begin
                n.buffer = newByte;
                n.stat[ST_BF] = 1'b1;
            end
        end
        // Select high realigns framing for the next transfer
        if (portReset) begin
            n.bitCnt = 3'h0;
            n.mst = MST_IDLE;
            n.divCnt = 8'h00;
            n.halfCnt = 4'h0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs; raw select gates the driver so release needs no sync delay
    assign avsReadData = r.rdData;
    assign avsWaitRequest = avsReq.read & ~r.rdValid;
    assign sdoOut = r.outBit;
    assign sdoOeN = ~(master | (slave & ~(ssCtl & ss)))
        | (slave & ssCtl & ssN);
    assign sckOut = r.mSck;
    assign sckOeN = ~master;
    assign irq = |(r.irqSt & r.irqMask);
    assign wakeReq = sleep & irq;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    sdo_float_a: assert property (
        (slave & ssCtl & ssN) |-> sdoOeN)
        else $error("data out driven with select high");

    sdo_drive_a: assert property (
        (slave & ssCtl & ~ssN & ~ss) |-> ~sdoOeN)
        else $error("data out floating with select low");

    ss_reset_a: assert property (
        (slave & ssCtl & ss) |=> (r.bitCnt == 3'h0))
        else $error("serial logic not reset by select");

    en_reset_a: assert property (
        ~en |=> (r.bitCnt == 3'h0) & (r.mst == MST_IDLE))
        else $error("counter not cleared when disabled");

    ss_ignore_a: assert property (
        (slave & ssCtl & ss & ~avsReq.write) |=> $stable(r.shifter))
        else $error("shifted while select high");

    frame_start_a: assert property (
        (slave & ssCtl & r.ssD & ~ss) |-> (r.bitCnt == 3'h0))
        else $error("frame began misaligned");

    sleep_shift_a: assert property (
        (slave & sleep & sampleE & (r.bitCnt != BIT_LAST))
        |=> (r.bitCnt == $past(r.bitCnt) + 3'h1))
        else $error("slave stopped shifting in sleep");

    byte_flag_a: assert property (
        byteDone & ~portReset |=> r.irqSt[IRQ_BYTE] & (r.bitCnt == 3'h0))
        else $error("byte end did not raise flag");

    buf_load_a: assert property (
        (byteDone & ~keepOld) |=> (r.buffer == $past(newByte))
        & r.stat[ST_BF])
        else $error("received byte not buffered");

    wr_coll_a: assert property (
        (wrBuf & busy & ~portReset) |=> r.con1[C1_WRITE_COLLISION_FLAG]
        & r.irqSt[IRQ_WRITE_COLLISION_FLAG])
        else $error("collision not flagged");

    mst_freeze_a: assert property (
        (master & (r.mst == MST_RUN) & sleep & ~avsReq.write)
        |=> $stable(r.mSck) & $stable(r.halfCnt) & $stable(r.divCnt))
        else $error("master moved during sleep");

    mst_resume_a: assert property (
        (mLead | mTrail) & (r.halfCnt != HALF_LAST) & ~avsReq.write
        |=> (r.mSck != $past(r.mSck)) & (r.mst == MST_RUN))
        else $error("master did not resume");

    // Guards on flags, buffer, counter hold-off, master end and disabled pins
    irq_level_a: assert property (
        (r.irqSt[IRQ_BYTE] & r.irqMask[IRQ_BYTE])
        |-> irq)
        else $error("unmasked byte flag without interrupt");

    wake_req_a: assert property (
        (byteDone & r.irqMask[IRQ_BYTE] & sleep & ~avsReq.write)
        |=> (wakeReq | ~sleep))
        else $error("received byte did not wake");

    ovf_keep_a: assert property (
        (byteDone & keepOld)
        |=> $stable(r.buffer) & r.con1[C1_OVF])
        else $error("unread byte overwritten");

    drop_load_a: assert property (
        (wrBuf & busy & ~byteDone)
        |=> $stable(r.buffer))
        else $error("buffer loaded while shifting");

    cnt_hold_a: assert property (
        (slave & ssCtl & ss)
        |=> ~byteDone)
        else $error("byte completed with select high");

    mst_end_a: assert property (
        ((mLead | mTrail) & (r.halfCnt == HALF_LAST))
        |=> (r.mst == MST_IDLE))
        else $error("master ran past its byte");

    en_float_a: assert property (
        ~en
        |-> sdoOeN & sckOeN)
        else $error("pins driven while disabled");

endmodule : sss_port
`default_nettype wire

// File: testbench/sss_ext_master.sv
`timescale 1ns/10ps
`default_nettype none
// Outside serial master; clock stands still between frames except in ticks
module sss_ext_master (
    output logic sck,
    output logic ssN,
    output logic serial_data_in,
    input wire logic serial_data_out
);
    // Idle level: select high, clock low
    initial begin
        sck = 1'b0;
        ssN = 1'b1;
        serial_data_in = 1'b0;
    end
    // Clock pulses with select high, which must be ignored
    task automatic ticks(input int n);
        #2; // Edges kept off the core clock edge
        repeat (n) begin
            #32 sck = 1'b1;
            #32 sck = 1'b0;
        end
    endtask : ticks
    // MSB first; data moves after the fall, sdo taken at the rise
    task automatic xfer(input logic [7:0] tx, input int n,
        input bit keep, output logic [7:0] rx);
        rx = 8'h00;
        #2; // Edges kept off the core clock edge
        ssN = 1'b0;
        #64;
        for (int i = 0; i < n; i++) begin
            serial_data_in = tx[7 - i];
            #32 sck = 1'b1;
            rx = {rx[6:0], serial_data_out};
            #32 sck = 1'b0;
        end
        serial_data_in = ~serial_data_in; // Stale level never looks valid
        #64;
        if (!keep) ssN = 1'b1;
    endtask : xfer
    // Select released at once, part way through a byte
    task automatic deselect();
        ssN = 1'b1;
    endtask : deselect
endmodule : sss_ext_master
`default_nettype wire

// File: testbench/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb
    import sss_pkg::*;
;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic sleep = 1'b0;
    sss_avs_req_s avsReq = '0;
    logic [31:0] avsReadData;
    logic avsWaitRequest, sckOut, sckOeN, sdoOut, sdoOeN, irq, wakeReq;
    wire sck, ssN, serial_data_in;
    wire sckLine = sckOeN ? sck : sckOut;
    // No pull on the data line: floats when released
    wire serial_data_out = sdoOeN ? 1'bz : sdoOut;
    int err_count = 0;
    int tests_run = 0;
    int toggles = 0;
    int t0, t1;
    logic prevSck = 1'b0;
    logic [31:0] d;
    logic [7:0] rx;

    sss_port i_sss_port (.core_clk(core_clk), .reset(reset),
        .avsReq(avsReq), .avsReadData(avsReadData),
        .avsWaitRequest(avsWaitRequest), .sckIn(sckLine),
        .sckOut(sckOut), .sckOeN(sckOeN), .ssN(ssN), .sdiIn(serial_data_in),
        .sdoOut(sdoOut), .sdoOeN(sdoOeN), .sleep(sleep), .irq(irq),
        .wakeReq(wakeReq));
    sss_ext_master i_sss_ext_master (.sck(sck), .ssN(ssN), .serial_data_in(serial_data_in),
        .serial_data_out(serial_data_out));

    // 125 MHz core clock
    initial forever #4 core_clk = ~core_clk;
    // Count master clock edges
    always @(posedge core_clk) begin
        prevSck <= sckOut;
        if (sckOut !== prevSck) toggles++;
    end
    //////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : print_verdict
    task automatic ck(input logic [31:0] g, e, input string m);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask : ck
    // One Avalon cycle, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [2:0] a,
        input logic [7:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge core_clk);
        avsReq <= '{~w, w, a, {24'h0, wd}};
        do begin
            @(posedge core_clk);
            n++;
        end while (avsWaitRequest !== 1'b0 && n < 20);
        rd = avsReadData;
        avsReq <= '0;
        if (n >= 20) begin
            ck(1'b0, 1'b1, "bus timeout");
            print_verdict();
        end
    endtask : bus
    task automatic frame(input logic [7:0] tx);
        i_sss_ext_master.xfer(tx, 8, 1'b0, rx);
        bus(1'b0, IDX_BUF, 8'h00, d);
        ck(d, {24'h0, tx}, "received byte");
    endtask : frame
    //////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        bus(1'b0, IDX_CON1, 8'h00, d);
        ck(d, 32'h0, "control reset");
        bus(1'b1, 3'h6, 8'hff, d);
        bus(1'b0, 3'h6, 8'h00, d);
        ck(d, 32'h0, "unmapped read");
        ck({irq, sdoOeN}, 2'h1, "pins after reset");
        $display("reset test done");
    endtask : t_reset
    task automatic t_frame();
        bus(1'b1, IDX_CON1, 8'h24, d);
        bus(1'b1, IDX_STAT, 8'h40, d);
        bus(1'b0, IDX_STAT, 8'h00, d);
        ck(d, 32'h40, "status readback");
        bus(1'b1, IDX_MASK, 8'h01, d);
        bus(1'b1, IDX_BUF, 8'ha5, d);
        ck(sdoOeN, 1'b1, "float while idle");
        sleep <= 1'b1;
        i_sss_ext_master.xfer(8'h3c, 8, 1'b0, rx);
        ck(rx, 8'ha5, "sent byte");
        @(posedge core_clk);
        ck(wakeReq, 1'b1, "wake on byte");
        bus(1'b0, IDX_BUF, 8'h00, d);
        ck(d, 32'h3c, "byte in sleep");
        bus(1'b0, IDX_STAT, 8'h00, d);
        ck(d, 32'h40, "full flag cleared by read");
        bus(1'b1, IDX_IRQ, 8'h01, d);
        @(posedge core_clk);
        ck(irq, 1'b0, "irq cleared");
        sleep <= 1'b0;
        $display("frame test done");
    endtask : t_frame
    task automatic t_partial();
        i_sss_ext_master.xfer(8'hff, 3, 1'b1, rx);
        ck(sdoOeN, 1'b0, "driven while selected");
        i_sss_ext_master.deselect();
        #1 ck(sdoOeN, 1'b1, "float at once");
        #63; // Select stays high long enough to pass the synchroniser
        frame(8'h96);
        i_sss_ext_master.ticks(5);
        frame(8'hc3);
        $display("framing test done");
    endtask : t_partial
    task automatic t_enable();
        i_sss_ext_master.xfer(8'hf0, 5, 1'b1, rx);
        bus(1'b1, IDX_CON1, 8'h04, d);
        bus(1'b1, IDX_CON1, 8'h24, d);
        frame(8'h69);
        $display("enable test done");
    endtask : t_enable
    task automatic t_collide();
        fork
            i_sss_ext_master.xfer(8'h00, 8, 1'b0, rx);
            begin
                repeat (24) @(posedge core_clk);
                bus(1'b1, IDX_BUF, 8'h11, d);
            end
        join
        bus(1'b0, IDX_CON1, 8'h00, d);
        ck(d, 32'ha4, "collision flag");
        bus(1'b0, IDX_IRQ, 8'h00, d);
        ck(d, 32'h03, "irq status");
        // Second byte while the first is unread: kept, overflow flagged
        i_sss_ext_master.xfer(8'h5a, 8, 1'b0, rx);
        bus(1'b0, IDX_CON1, 8'h00, d);
        ck(d, 32'he4, "overflow flag");
        bus(1'b1, IDX_CON1, 8'h24, d);
        bus(1'b0, IDX_CON1, 8'h00, d);
        ck(d, 32'h24, "software clear");
        bus(1'b0, IDX_BUF, 8'h00, d);
        ck(d, 32'h00, "buffer kept");
        bus(1'b1, IDX_IRQ, 8'h03, d);
        $display("collision test done");
    endtask : t_collide
    task automatic t_master();
        bus(1'b1, IDX_CON1, 8'h20, d);
        t0 = toggles;
        bus(1'b1, IDX_BUF, 8'h5a, d);
        repeat (8) @(posedge core_clk);
        sleep <= 1'b1;
        repeat (2) @(posedge core_clk);
        t1 = toggles;
        repeat (20) @(posedge core_clk);
        ck(toggles, t1, "frozen in sleep");
        ck(sckOeN, 1'b0, "clock driven");
        sleep <= 1'b0;
        repeat (60) @(posedge core_clk);
        ck(toggles - t0, 16, "resumed byte");
        $display("master test done");
    endtask : t_master
    //////////////////////////////////////////////////////////////////////
    // Main sequence after three reset cycles
    initial begin
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        t_reset();
        t_frame();
        t_partial();
        t_enable();
        t_collide();
        t_master();
        print_verdict();
    end
    // Watchdog well past the few thousand nanoseconds needed
    initial begin
        #200000;
        err_count++;
        print_verdict();
    end
endmodule : tb
`default_nettype wire
